/* rclm_pkg.sv */
// Shared constants, timing counts and types of the receive lane manager
package rclm_pkg;

   // Control clock rate and derived cycles per microsecond
   localparam int CLK_HZ     = 10_000_000;
   localparam int CLK_PER_US = CLK_HZ / 1_000_000;

   // Least settle time in lock-to-reference before trying the data
   localparam int REF_SETTLE_US  = 20;
   localparam int REF_SETTLE_CYC = (REF_SETTLE_US * CLK_PER_US < 1) ?
                                   1 : REF_SETTLE_US * CLK_PER_US;

   // Longest wait for fine lock after entering lock-to-data
   localparam int LOCK_WAIT_US  = 200;
   localparam int LOCK_WAIT_CYC = (LOCK_WAIT_US * CLK_PER_US < 1) ?
                                  1 : LOCK_WAIT_US * CLK_PER_US;

   // Longest calibration run before the lane is restarted
   localparam int CAL_TIMEOUT_US  = 10_000;
   localparam int CAL_TIMEOUT_CYC = (CAL_TIMEOUT_US * CLK_PER_US < 1) ?
                                    1 : CAL_TIMEOUT_US * CLK_PER_US;

   // Shared cycle counter width
   localparam int CNT_W = 20;
   localparam logic [CNT_W-1:0] REF_SETTLE_LAST = CNT_W'(REF_SETTLE_CYC - 1);
   localparam logic [CNT_W-1:0] LOCK_WAIT_LAST  = CNT_W'(LOCK_WAIT_CYC - 1);

   // Requester hold time before it gives up on an answer
   localparam int HOLD_W = 8;
   localparam logic [HOLD_W-1:0] REQ_HOLD_LAST = 8'h3F;

   // Bit positions in the manager synchroniser vector
   localparam int SY_LOS   = 0;
   localparam int SY_CAL   = 1;
   localparam int SY_EYE   = 2;
   localparam int SY_COEFF = 3;
   localparam int SY_LOCK  = 4;
   localparam int SY_PDONE = 5;
   localparam int SY_N     = 6;

   // Request channel indices
   localparam int CH_CAL   = 0;
   localparam int CH_EYE   = 1;
   localparam int CH_COEFF = 2;
   localparam int N_CH     = 3;

   // Kind of calibration handed to the transceiver engine
   typedef enum logic [1:0] {
      CAL_NONE  = 2'b00,
      CAL_FULL  = 2'b01,
      CAL_EYE   = 2'b10,
      CAL_COEFF = 2'b11
   } rclm_cal_kind_t;

   // Manager states
   typedef enum logic [2:0] {
      ST_REF    = 3'b000,
      ST_DATA   = 3'b001,
      ST_CAL    = 3'b010,
      ST_RUN    = 3'b011,
      ST_BYPASS = 3'b100
   } rclm_state_t;

endpackage

/* rclm_if.sv */
// Handshake wires between the lane manager and the user fabric logic
`timescale 1ns/1ps
interface rclm_if;
   logic lane_signal_absent;
   logic lane_cal_request;
   logic lane_eye_recal_request;
   logic lane_coeff_recal_request;
   logic lane_calibrating;
   logic lane_cal_done;
   logic lane_eye_recal_done;
   logic lane_coeff_recal_done;
   logic lane_rx_valid;

   // Manager end
   modport mgr (
      input  lane_signal_absent,
      input  lane_cal_request,
      input  lane_eye_recal_request,
      input  lane_coeff_recal_request,
      output lane_calibrating,
      output lane_cal_done,
      output lane_eye_recal_done,
      output lane_coeff_recal_done,
      output lane_rx_valid
   );

   // User fabric end
   modport usr (
      output lane_signal_absent,
      output lane_cal_request,
      output lane_eye_recal_request,
      output lane_coeff_recal_request,
      input  lane_calibrating,
      input  lane_cal_done,
      input  lane_eye_recal_done,
      input  lane_coeff_recal_done,
      input  lane_rx_valid
   );
endinterface

/* rclm_sync.sv */
// Two-flop synchroniser with a rising-edge detector behind it
`timescale 1ns/1ps
module rclm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level_out,
   output logic      [W-1:0] rise_out
);
   import rclm_pkg::*;

   logic [W-1:0] meta_reg;
   logic [W-1:0] stable_reg;
   logic [W-1:0] delay_reg;

   // Refuse a zero width while the design is built
   if (W < 1) begin : g_bad_width
      $error("rclm_sync: width must be at least one");
   end

   // Meta stage feeds only the stable stage; edges look at later stages
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_reg   <= '0;
         stable_reg <= '0;
         delay_reg  <= '0;
      end else begin
         meta_reg   <= async_in;
         stable_reg <= meta_reg;
         delay_reg  <= stable_reg;
      end
   end

   // Outputs
   assign level_out = stable_reg;
   assign rise_out  = stable_reg & ~delay_reg;
endmodule

/* rclm_rx_link_manager.sv */
// Receive lane manager: lock mode control and calibration sequencing
// Functional notes
// - Management logic runs on the dedicated control clock
// - Reset driven from transceiver init complete
// - Signal absent holds PLL in lock-to-reference
// - Signal absent ignored after lock-to-data entry
// - Signal absent released only with valid data
// - Active-high request starts on-demand calibration
// - One calibration per request rising edge
// - Calibrating high while calibration runs
// - Optional automatic calibration at first bit lock
// - Request ignored when on-demand option absent
// - Optional eye and coefficient recalibration requests
// - Done indication after full calibration finishes
// - Manager switches PLL between reference and data
// - Relock on its own after traffic loss
// - Lock takes about three times longer
// - Manager disabled leaves plain pass-through lane
// - Valid only with fine lock and idle
// - Each recalibration answers with its done
// - Recalibration only after one full calibration
`timescale 1ns/1ps
module rclm_rx_link_manager #(
   parameter bit MGR_EN          = 1'b1,
   parameter bit AUTO_FIRST_LOCK = 1'b1,
   parameter bit ON_DEMAND_EN    = 1'b1,
   parameter bit EYE_RECAL_EN    = 1'b1,
   parameter bit COEFF_RECAL_EN  = 1'b1,
   parameter int CAL_TIMEOUT_CYC = rclm_pkg::CAL_TIMEOUT_CYC
) (
   input  wire logic                    clk_in,
   input  wire logic                    rstn_in,
   rclm_if.mgr                          lane,
   input  wire logic                    cdr_fine_lock_in,
   input  wire logic                    pma_cal_done_in,
   output logic                         pll_lock_to_data_out,
   output logic                         pma_cal_start_out,
   output rclm_pkg::rclm_cal_kind_t     pma_cal_kind_out
);
   import rclm_pkg::*;

   localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_TIMEOUT_CYC - 1);

   if (CAL_TIMEOUT_CYC < 1 || CAL_TIMEOUT_CYC >= (1 << CNT_W)) begin : g_chk
      $error("rclm_rx_link_manager: timeout does not fit the counter");
   end

   // Reset release synchroniser; assertion stays asynchronous
   logic rst_meta_reg;
   logic mgmt_rstn_reg;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_reg  <= 1'b0;
         mgmt_rstn_reg <= 1'b0;
      end else begin
         rst_meta_reg  <= 1'b1;
         mgmt_rstn_reg <= rst_meta_reg;
      end
   end

   // Every lane and transceiver input crosses in through two flops
   logic [SY_N-1:0] sync_raw;
   logic [SY_N-1:0] lvl;
   logic [SY_N-1:0] rise;

   assign sync_raw[SY_LOS]   = lane.lane_signal_absent;
   assign sync_raw[SY_CAL]   = lane.lane_cal_request;
   assign sync_raw[SY_EYE]   = lane.lane_eye_recal_request;
   assign sync_raw[SY_COEFF] = lane.lane_coeff_recal_request;
   assign sync_raw[SY_LOCK]  = cdr_fine_lock_in;
   assign sync_raw[SY_PDONE] = pma_cal_done_in;

   rclm_sync #(
      .W (SY_N)
   ) u_sync (
      .clk_in    (clk_in),
      .rstn_in   (mgmt_rstn_reg),
      .async_in  (sync_raw),
      .level_out (lvl),
      .rise_out  (rise)
   );

   // Manager state
   rclm_state_t      state_reg,       state_next;
   logic [CNT_W-1:0] cnt_reg,         cnt_next;
   logic [N_CH-1:0]  pend_reg,        pend_next;
   logic [N_CH-1:0]  new_req;
   rclm_cal_kind_t   kind_reg,        kind_next;
   logic             start_reg,       start_next;
   logic             l2d_reg,         l2d_next;
   logic             calib_reg,       calib_next;
   logic             cal_done_reg,    cal_done_next;
   logic             eye_done_reg,    eye_done_next;
   logic             coeff_done_reg,  coeff_done_next;
   logic             once_reg,        once_next;
   logic             first_reg,       first_next;
   logic             rx_valid_reg,    rx_valid_next;

   // Edges kept only for options present; early recals are dropped
   always_comb begin
      new_req[CH_CAL]   = MGR_EN & ON_DEMAND_EN & rise[SY_CAL];
      new_req[CH_EYE]   = MGR_EN & EYE_RECAL_EN & once_reg
                          & rise[SY_EYE];
      new_req[CH_COEFF] = MGR_EN & COEFF_RECAL_EN & once_reg
                          & rise[SY_COEFF];
   end

   // Next-state logic; a new edge in a clearing cycle survives
   always_comb begin
      state_next      = state_reg;
      cnt_next        = cnt_reg;
      pend_next       = pend_reg;
      kind_next       = kind_reg;
      start_next      = 1'b0;
      l2d_next        = l2d_reg;
      calib_next      = 1'b0;
      cal_done_next   = cal_done_reg;
      eye_done_next   = eye_done_reg & lvl[SY_EYE];
      coeff_done_next = coeff_done_reg & lvl[SY_COEFF];
      once_next       = once_reg;
      first_next      = first_reg;
      rx_valid_next   = 1'b0;

      case (state_reg)
         ST_REF: begin
            l2d_next = 1'b0;
            if (!MGR_EN) begin
               state_next = ST_BYPASS;
            end else if (lvl[SY_LOS]) begin
               cnt_next = '0;
            end else if (cnt_reg >= REF_SETTLE_LAST) begin
               cnt_next   = '0;
               l2d_next   = 1'b1;
               state_next = ST_DATA;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         // Signal absent is no longer looked at here
         ST_DATA: begin
            if (lvl[SY_LOCK]) begin
               cnt_next   = '0;
               first_next = 1'b1;
               if (AUTO_FIRST_LOCK && !first_reg) begin
                  kind_next     = CAL_FULL;
                  start_next    = 1'b1;
                  calib_next    = 1'b1;
                  cal_done_next = 1'b0;
                  state_next    = ST_CAL;
               end else begin
                  state_next = ST_RUN;
               end
            end else if (cnt_reg >= LOCK_WAIT_LAST) begin
               cnt_next   = '0;
               l2d_next   = 1'b0;
               state_next = ST_REF;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         // Engine running; done edge ends it in the same edge for all
         ST_CAL: begin
            calib_next = 1'b1;
            if (rise[SY_PDONE]) begin
               calib_next = 1'b0;
               cnt_next   = '0;
               state_next = ST_RUN;
               case (kind_reg)
                  CAL_FULL:  {cal_done_next, once_next} = 2'b11;
                  CAL_EYE:   eye_done_next   = 1'b1;
                  CAL_COEFF: coeff_done_next = 1'b1;
                  default:   cal_done_next   = cal_done_reg;
               endcase
            end else if (cnt_reg >= CAL_LAST) begin
               // A hung engine restarts the lane rather than stalling it
               calib_next = 1'b0;
               cnt_next   = '0;
               l2d_next   = 1'b0;
               state_next = ST_REF;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         // Locked; serve one pending request at a time, full first
         ST_RUN: begin
            if (!lvl[SY_LOCK]) begin
               l2d_next   = 1'b0;
               cnt_next   = '0;
               state_next = ST_REF;
            end else if (pend_reg != '0) begin
               start_next = 1'b1;
               calib_next = 1'b1;
               cnt_next   = '0;
               state_next = ST_CAL;
               if (pend_reg[CH_CAL]) begin
                  pend_next[CH_CAL] = 1'b0;
                  kind_next         = CAL_FULL;
                  cal_done_next     = 1'b0;
               end else if (pend_reg[CH_EYE]) begin
                  pend_next[CH_EYE] = 1'b0;
                  kind_next         = CAL_EYE;
                  eye_done_next     = 1'b0;
               end else begin
                  pend_next[CH_COEFF] = 1'b0;
                  kind_next           = CAL_COEFF;
                  coeff_done_next     = 1'b0;
               end
            end else begin
               rx_valid_next = 1'b1;
            end
         end
         // No management at all: the lane tracks data, valid is lock
         ST_BYPASS: begin
            l2d_next      = 1'b1;
            rx_valid_next = lvl[SY_LOCK];
         end
         default: begin
            state_next = ST_REF;
         end
      endcase
      pend_next = pend_next | new_req;
   end

   // State registers
   always_ff @(posedge clk_in or negedge mgmt_rstn_reg) begin
      if (!mgmt_rstn_reg) begin
         state_reg      <= ST_REF;
         cnt_reg        <= '0;
         pend_reg       <= '0;
         kind_reg       <= CAL_NONE;
         start_reg      <= 1'b0;
         l2d_reg        <= 1'b0;
         calib_reg      <= 1'b0;
         cal_done_reg   <= 1'b0;
         eye_done_reg   <= 1'b0;
         coeff_done_reg <= 1'b0;
         once_reg       <= 1'b0;
         first_reg      <= 1'b0;
         rx_valid_reg   <= 1'b0;
      end else begin
         state_reg      <= state_next;
         cnt_reg        <= cnt_next;
         pend_reg       <= pend_next;
         kind_reg       <= kind_next;
         start_reg      <= start_next;
         l2d_reg        <= l2d_next;
         calib_reg      <= calib_next;
         cal_done_reg   <= cal_done_next;
         eye_done_reg   <= eye_done_next;
         coeff_done_reg <= coeff_done_next;
         once_reg       <= once_next;
         first_reg      <= first_next;
         rx_valid_reg   <= rx_valid_next;
      end
   end

   // Outputs straight from registers
   assign pll_lock_to_data_out       = l2d_reg;
   assign pma_cal_start_out          = start_reg;
   assign pma_cal_kind_out           = kind_reg;
   assign lane.lane_calibrating      = calib_reg;
   assign lane.lane_cal_done         = cal_done_reg;
   assign lane.lane_eye_recal_done   = eye_done_reg;
   assign lane.lane_coeff_recal_done = coeff_done_reg;
   assign lane.lane_rx_valid         = rx_valid_reg;
endmodule

/* rclm_user_end.sv */
// User fabric end: raises edge requests and watches lane status
`timescale 1ns/1ps
module rclm_user_end (
   input  wire logic clk_in,
   input  wire logic rstn_in,
   rclm_if.usr       lane,
   input  wire logic signal_absent_in,
   input  wire logic cal_go_in,
   input  wire logic eye_go_in,
   input  wire logic coeff_go_in,
   output logic      busy_out,
   output logic      cal_done_out,
   output logic      eye_done_out,
   output logic      coeff_done_out,
   output logic      rx_valid_out
);
   import rclm_pkg::*;

   // Optical module pin is foreign to this clock
   logic los_lvl;

   rclm_sync #(
      .W (1)
   ) u_los_sync (
      .clk_in    (clk_in),
      .rstn_in   (rstn_in),
      .async_in  (signal_absent_in),
      .level_out (los_lvl),
      .rise_out  ()
   );

   logic [N_CH-1:0] go;
   logic [N_CH-1:0] ack;
   logic [N_CH-1:0] req_lvl;

   assign go[CH_CAL]    = cal_go_in;
   assign go[CH_EYE]    = eye_go_in;
   assign go[CH_COEFF]  = coeff_go_in;
   assign ack[CH_CAL]   = lane.lane_calibrating;
   assign ack[CH_EYE]   = lane.lane_eye_recal_done;
   assign ack[CH_COEFF] = lane.lane_coeff_recal_done;

   // One requester per channel; drop on answer so the next go is an edge
   for (genvar i = 0; i < N_CH; i++) begin : g_ch
      logic              r_reg;
      logic              r_next;
      logic [HOLD_W-1:0] hold_reg;
      logic [HOLD_W-1:0] hold_next;

      always_comb begin
         r_next    = r_reg;
         hold_next = hold_reg;
         if (r_reg) begin
            if (ack[i] || hold_reg >= REQ_HOLD_LAST) begin
               r_next = 1'b0;
            end else begin
               hold_next = hold_reg + 1'b1;
            end
         end else if (go[i] && !ack[i]) begin
            r_next    = 1'b1;
            hold_next = '0;
         end
      end

      always_ff @(posedge clk_in or negedge rstn_in) begin
         if (!rstn_in) begin
            r_reg    <= 1'b0;
            hold_reg <= '0;
         end else begin
            r_reg    <= r_next;
            hold_reg <= hold_next;
         end
      end

      assign req_lvl[i] = r_reg;
   end

   // Registered status toward the rest of the fabric
   logic los_reg;
   logic busy_reg;
   logic cal_done_reg;
   logic eye_done_reg;
   logic coeff_done_reg;
   logic rx_valid_reg;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         los_reg        <= 1'b1; // Absent in reset only; present for two cycles until the pin arrives
         busy_reg       <= 1'b0;
         cal_done_reg   <= 1'b0;
         eye_done_reg   <= 1'b0;
         coeff_done_reg <= 1'b0;
         rx_valid_reg   <= 1'b0;
      end else begin
         los_reg        <= los_lvl;
         busy_reg       <= (|req_lvl) | lane.lane_calibrating;
         cal_done_reg   <= lane.lane_cal_done;
         eye_done_reg   <= lane.lane_eye_recal_done;
         coeff_done_reg <= lane.lane_coeff_recal_done;
         rx_valid_reg   <= lane.lane_rx_valid;
      end
   end

   assign lane.lane_signal_absent       = los_reg;
   assign lane.lane_cal_request         = req_lvl[CH_CAL];
   assign lane.lane_eye_recal_request   = req_lvl[CH_EYE];
   assign lane.lane_coeff_recal_request = req_lvl[CH_COEFF];
   assign busy_out       = busy_reg;
   assign cal_done_out   = cal_done_reg;
   assign eye_done_out   = eye_done_reg;
   assign coeff_done_out = coeff_done_reg;
   assign rx_valid_out   = rx_valid_reg;
endmodule

/* rclm_rx_link_manager_monitor.sv */
// Checker on the handshake wires between the two lane ends
`timescale 1ns/1ps
module rclm_monitor (
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic lane_cal_request,
   input  wire logic lane_eye_recal_request,
   input  wire logic lane_coeff_recal_request,
   input  wire logic lane_calibrating,
   input  wire logic lane_cal_done,
   input  wire logic lane_eye_recal_done,
   input  wire logic lane_coeff_recal_done,
   input  wire logic lane_rx_valid
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   // Each done answer lands on the edge where calibrating drops
   full_done_fall_a: assert property (
      $rose(lane_cal_done) |-> $fell(lane_calibrating))
      else $error("full done without calibrating falling");
   eye_done_fall_a: assert property (
      $rose(lane_eye_recal_done) |-> $fell(lane_calibrating))
      else $error("eye done without calibrating falling");
   coeff_done_fall_a: assert property (
      $rose(lane_coeff_recal_done) |-> $fell(lane_calibrating))
      else $error("coeff done without calibrating falling");
   // Valid never overlaps a running calibration
   valid_idle_a: assert property (
      lane_rx_valid |-> !lane_calibrating)
      else $error("rx valid while calibrating");
   // Full done only clears when the next full run starts
   cal_done_hold_a: assert property (
      $fell(lane_cal_done) |-> $rose(lane_calibrating))
      else $error("full done dropped outside a new run");
   // Recal answers stand while their request is still up
   eye_ack_hold_a: assert property (
      lane_eye_recal_done && lane_eye_recal_request |=> lane_eye_recal_done)
      else $error("eye done dropped under request");
   coeff_ack_hold_a: assert property (
      lane_coeff_recal_done && lane_coeff_recal_request
      |=> lane_coeff_recal_done)
      else $error("coeff done dropped under request");
   // Recalibration answers only after a completed full run
   eye_after_full_a: assert property (
      $rose(lane_eye_recal_done) |-> lane_cal_done)
      else $error("eye recal before any full run");
   coeff_after_full_a: assert property (
      $rose(lane_coeff_recal_done) |-> lane_cal_done)
      else $error("coeff recal before any full run");
   // A fresh request edge in a valid lane starts a run quickly
   demand_start_a: assert property (
      $rose(lane_cal_request) && lane_rx_valid |-> ##[1:6] lane_calibrating)
      else $error("request edge did not start a run");
endmodule

/* rclm_rx_link_manager_tb.sv */
// Bench joining both lane ends, with the engine and lock driven by hand
`timescale 1ns/1ps
module rclm_rx_link_manager_tb;
   import rclm_pkg::*;
   localparam int CAL_TO  = 50; // Shortened calibration timeout
   localparam int ENG_DLY = 10; // Engine run length in cycles
   logic           clk_in = 1'b0;
   logic           rstn_in;
   logic           fine_lock;
   logic           pma_done;
   logic           absent;
   logic           cal_go;
   logic           eye_go;
   logic           coeff_go;
   logic           to_data;
   logic           cal_start;
   rclm_cal_kind_t cal_kind;
   logic           busy;
   logic           cal_done;
   logic           eye_done;
   logic           coeff_done;
   logic           rx_valid;
   int             eng_cnt;
   int             eng_dly;
   int             starts;
   int             waited;
   rclm_cal_kind_t kinds[$];
   int             bad_count;
   int             check_count;

   always #50 clk_in = ~clk_in;

   rclm_if rclm_if_i ();
   rclm_rx_link_manager #(.CAL_TIMEOUT_CYC(CAL_TO)) rclm_rx_link_manager_i (
      .clk_in               (clk_in),
      .rstn_in              (rstn_in),
      .lane                 (rclm_if_i.mgr),
      .cdr_fine_lock_in     (fine_lock),
      .pma_cal_done_in      (pma_done),
      .pll_lock_to_data_out (to_data),
      .pma_cal_start_out    (cal_start),
      .pma_cal_kind_out     (cal_kind));
   rclm_user_end rclm_user_end_i (
      .clk_in           (clk_in),
      .rstn_in          (rstn_in),
      .lane             (rclm_if_i.usr),
      .signal_absent_in (absent),
      .cal_go_in        (cal_go),
      .eye_go_in        (eye_go),
      .coeff_go_in      (coeff_go),
      .busy_out         (busy),
      .cal_done_out     (cal_done),
      .eye_done_out     (eye_done),
      .coeff_done_out   (coeff_done),
      .rx_valid_out     (rx_valid));
   rclm_monitor rclm_monitor_i (
      .clk_in                   (clk_in),
      .rstn_in                  (rstn_in),
      .lane_cal_request         (rclm_if_i.lane_cal_request),
      .lane_eye_recal_request   (rclm_if_i.lane_eye_recal_request),
      .lane_coeff_recal_request (rclm_if_i.lane_coeff_recal_request),
      .lane_calibrating         (rclm_if_i.lane_calibrating),
      .lane_cal_done            (rclm_if_i.lane_cal_done),
      .lane_eye_recal_done      (rclm_if_i.lane_eye_recal_done),
      .lane_coeff_recal_done    (rclm_if_i.lane_coeff_recal_done),
      .lane_rx_valid            (rclm_if_i.lane_rx_valid));

   // Engine stand-in: logs each start, answers after eng_dly cycles
   always @(negedge clk_in) begin
      if (cal_start === 1'b1) begin
         starts++;
         kinds.push_back(cal_kind);
         pma_done = 1'b0;
         eng_cnt = eng_dly;
      end else if (eng_cnt > 0) begin
         eng_cnt--;
         if (eng_cnt == 0) begin
            pma_done = 1'b1;
         end
      end
   end

   task automatic check(input bit ok, input string what);
      check_count++;
      if (!ok) begin
         bad_count++;
         $display("wrong value at %0t ns: %s", $time, what);
      end
   endtask

   function automatic logic sig(input int s);
      case (s)
         0: return to_data;
         1: return busy;
         2: return cal_done;
         3: return eye_done;
         4: return coeff_done;
         default: return rx_valid;
      endcase
   endfunction

   // Bounded wait on one output; a miss counts as a mismatch
   task automatic wait_lvl(input int s, input logic v, input int lim,
                           input string what);
      waited = 0;
      while (sig(s) !== v && waited < lim) begin
         @(negedge clk_in);
         waited++;
      end
      check(sig(s) === v, what);
   endtask

   // Requests go as one-cycle pulses; the user end holds them
   task automatic go(input logic [2:0] m);
      cal_go = m[0];
      eye_go = m[1];
      coeff_go = m[2];
      @(negedge clk_in);
      cal_go = 1'b0;
      eye_go = 1'b0;
      coeff_go = 1'b0;
   endtask

   task automatic t_lock_first();
      absent = 1'b1;
      repeat (300) @(negedge clk_in);
      go(3'b010); // Early eye request, must be dropped
      check(to_data === 1'b0, "left reference while absent");
      absent = 1'b0;
      wait_lvl(0, 1'b1, 3 * REF_SETTLE_CYC, "no data entry");
      check(waited >= REF_SETTLE_CYC, "data entry too soon");
      absent = 1'b1;
      repeat (20) @(negedge clk_in);
      check(to_data === 1'b1, "late absent took effect");
      fine_lock = 1'b1;
      wait_lvl(2, 1'b1, 200, "no first-lock calibration");
      check(starts === 1 && kinds[0] === CAL_FULL, "first run");
      check(eye_done === 1'b0, "early recal answered");
      wait_lvl(5, 1'b1, 20, "no valid after run");
      check(starts === 1 && eye_done === 1'b0, "early recal run");
      absent = 1'b0;
   endtask

   task automatic t_demand();
      starts = 0;
      kinds.delete();
      go(3'b011); // Full and eye in the same cycle
      wait_lvl(1, 1'b1, 10, "busy missing");
      wait_lvl(3, 1'b1, 200, "eye answer missing");
      check(starts === 2 && kinds[0] === CAL_FULL, "full first");
      check(kinds[1] === CAL_EYE, "eye second");
      go(3'b100);
      wait_lvl(4, 1'b1, 200, "coeff answer missing");
      check(starts === 3 && kinds[2] === CAL_COEFF, "coeff run");
      wait_lvl(1, 1'b0, 20, "busy stuck");
      check(starts === 3 && rx_valid === 1'b1, "extra run");
   endtask

   task automatic t_relock();
      starts = 0;
      fine_lock = 1'b0;
      wait_lvl(5, 1'b0, 10, "valid without lock");
      wait_lvl(0, 1'b0, 10, "kept data mode");
      wait_lvl(0, 1'b1, 3 * REF_SETTLE_CYC, "no retry");
      fine_lock = 1'b1;
      wait_lvl(5, 1'b1, 20, "no relock");
      check(starts === 0, "auto run repeated");
   endtask

   // Engine slower than the timeout: no done, lane restarts
   task automatic t_timeout();
      eng_dly = 2 * CAL_TO;
      go(3'b001);
      wait_lvl(1, 1'b1, 10, "busy missing");
      wait_lvl(0, 1'b0, CAL_TO + 20, "no restart on timeout");
      check(cal_done === 1'b0, "done without engine");
      wait_lvl(5, 1'b1, 3 * REF_SETTLE_CYC, "no valid after restart");
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      rstn_in = 1'b0;
      {fine_lock, pma_done, absent, cal_go, eye_go, coeff_go} = 6'h00;
      {eng_cnt, starts, bad_count, check_count} = '0;
      eng_dly = ENG_DLY;
      repeat (4) @(negedge clk_in);
      rstn_in = 1'b1;
      repeat (3) @(negedge clk_in);
      t_lock_first();
      t_demand();
      t_relock();
      t_timeout();
      wrap_up();
   end

   // Watchdog sized well past the slow, tripled lock time
   initial begin
      #(20_000 * 100);
      bad_count++;
      $display("wrong value at %0t ns: run hung", $time);
      wrap_up();
   end
endmodule
